// ==== uart_regs_pkg.sv ====
package uart_regs_pkg;
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_MASK = 3'h1;
   localparam logic [2:0] OFS_SRC = 3'h2;
   localparam logic [2:0] OFS_LFC = 3'h3;
   localparam logic [2:0] OFS_MOC = 3'h4;
   localparam logic [2:0] OFS_LINE = 3'h5;
   localparam logic [2:0] OFS_MIC = 3'h6;
   localparam logic [2:0] OFS_SCR = 3'h7;
   localparam int QUEUE_DEPTH = 16;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] MASK_WR_BITS = 8'h2F;
   localparam logic [7:0] LFC_RST = 8'h00;
   localparam logic [7:0] MOC_RST = 8'h00;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [7:0] SCR_RST = 8'h00;
   localparam int MASK_RX = 0;
   localparam int MASK_TX = 1;
   localparam int MASK_LINE = 2;
   localparam int MASK_MODEM = 3;
   localparam int MASK_SPECIAL = 5;
   localparam int LFC_DIV = 7;
   localparam int QC_EN = 0;
   localparam int QC_RXCLR = 1;
   localparam int QC_TXCLR = 2;
   localparam int QC_DMA = 3;
   localparam int QC_TXSEL = 4;
   localparam int QC_RXSEL = 6;
   localparam int MOC_DTR = 0;
   localparam int MOC_RTS = 1;
   localparam int MOC_SOFT = 2;
   localparam int MOC_INTEN = 3;
   localparam int MOC_LOOP = 4;
   localparam int MOC_PDOWN = 7;
   localparam logic [7:0] MOC_RD_BITS = 8'h9F;
   localparam logic [4:0] TRIG_0 = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h04;
   localparam logic [4:0] TRIG_2 = 5'h08;
   localparam logic [4:0] TRIG_3 = 5'h0E;
   localparam logic [3:0] CODE_LINE = 4'h6;
   localparam logic [3:0] CODE_RX = 4'h4;
   localparam logic [3:0] CODE_TX = 4'h2;
   localparam logic [3:0] CODE_MODEM = 4'h0;
   localparam logic [3:0] CODE_NONE = 4'h1;
endpackage

// ==== byte_queue.sv ====
`timescale 1ns/100ps
module byte_queue #(
   parameter int W = 8,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH),
   parameter int LW = $clog2(DEPTH + 1)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic push,
   input wire logic [W-1:0] pushData,
   input wire logic pop,
   output logic [W-1:0] headData,
   output logic [LW-1:0] level,
   output logic empty,
   output logic full
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [LW-1:0] count_r;
   logic doPush;
   logic doPop;

   assign empty = (count_r == '0);
   assign full = (count_r == LW'(DEPTH));
   assign level = count_r;
   assign headData = mem[rdPtr_r];
   assign doPush = push && !full;
   assign doPop = pop && !empty;

   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_r] <= pushData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else if (clear) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (doPush) begin
            wrPtr_r <= AW'(wrPtr_r + 1'b1);
         end
         if (doPop) begin
            rdPtr_r <= AW'(rdPtr_r + 1'b1);
         end
         if (doPush && !doPop) begin
            count_r <= LW'(count_r + 1'b1);
         end else if (doPop && !doPush) begin
            count_r <= LW'(count_r - 1'b1);
         end
      end
   end
endmodule

// ==== uart_register_map.sv ====
`timescale 1ns/100ps
module uart_register_map #(
   parameter int DEPTH = uart_regs_pkg::QUEUE_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] addr,
   input wire logic rdEn,
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   output logic [7:0] rdData,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxParityErr,
   input wire logic rxFrameErr,
   input wire logic rxBreak,
   output logic [7:0] txData,
   output logic txAvail,
   input wire logic txTake,
   input wire logic txShifterEmpty,
   input wire logic ctsN,
   input wire logic dsrN,
   input wire logic riN,
   input wire logic cdN,
   output logic intrOut,
   output logic [7:0] lineFormat,
   output logic [15:0] divisor,
   output logic dtrN,
   output logic rtsN,
   output logic loopback,
   output logic powerDown,
   output logic softRstOut,
   output logic dmaMode
);
   localparam int LW = $clog2(DEPTH + 1);

   logic [7:0] mask_r;
   logic [7:0] lfc_r;
   logic [7:0] moc_r;
   logic [7:0] divLo_r;
   logic [7:0] divHi_r;
   logic [7:0] scr_r;
   logic [7:0] rdData_r;
   logic qEn_r;
   logic dma_r;
   logic [1:0] txSel_r;
   logic [1:0] rxSel_r;
   logic overrun_r;
   logic lineAck_r;
   logic [LW-1:0] errCount_r;
   logic txInt_r;
   logic txBelow_r;
   logic txMaskPrev_r;
   logic [3:0] modemMeta_r;
   logic [3:0] modemSync_r;
   logic [3:0] modemPrev_r;
   logic [3:0] delta_r;

   logic dlab;
   logic special;
   logic rdHold;
   logic wrHold;
   logic rdLine;
   logic rdModem;
   logic wrQc;
   logic rxClr;
   logic txClr;
   logic [10:0] rxHead;
   logic [LW-1:0] rxLevel;
   logic rxEmpty;
   logic rxQFull;
   logic rxFullEff;
   logic rxPush;
   logic rxPop;
   logic overrunEvt;
   logic [LW-1:0] txLevel;
   logic txEmpty;
   logic txQFull;
   logic txFullEff;
   logic txPush;
   logic [4:0] rxTrig;
   logic [4:0] txTrig;
   logic [2:0] headErr;
   logic txBelow;
   logic txSet;
   logic lineInt;
   logic rxInt;
   logic modemInt;
   logic [3:0] srcCode;
   logic [7:0] lineVal;
   logic [7:0] srcVal;
   logic [7:0] modemVal;
   logic [7:0] rdMux;

   function automatic logic [4:0] trigLevel(input logic [1:0] sel);
      unique case (sel)
         2'h0: trigLevel = uart_regs_pkg::TRIG_0;
         2'h1: trigLevel = uart_regs_pkg::TRIG_1;
         2'h2: trigLevel = uart_regs_pkg::TRIG_2;
         2'h3: trigLevel = uart_regs_pkg::TRIG_3;
      endcase
   endfunction

   assign dlab = lfc_r[uart_regs_pkg::LFC_DIV];
   assign special = mask_r[uart_regs_pkg::MASK_SPECIAL];

   // Reads and writes at a shared offset reach different registers.
   assign rdHold = rdEn && addr == uart_regs_pkg::OFS_DATA && !dlab;
   assign wrHold = wrEn && addr == uart_regs_pkg::OFS_DATA && !dlab;
   assign rdLine = rdEn && addr == uart_regs_pkg::OFS_LINE;
   assign rdModem = rdEn && addr == uart_regs_pkg::OFS_MIC;
   assign wrQc = wrEn && addr == uart_regs_pkg::OFS_SRC;

   // Queue clears only act while the enable bit of the same write is set.
   assign rxClr = wrQc && wrData[uart_regs_pkg::QC_EN] &&
                  wrData[uart_regs_pkg::QC_RXCLR];
   assign txClr = wrQc && wrData[uart_regs_pkg::QC_EN] &&
                  wrData[uart_regs_pkg::QC_TXCLR];

   // Without queues each side holds a single character.
   assign rxFullEff = qEn_r ? rxQFull : !rxEmpty;
   assign txFullEff = qEn_r ? txQFull : !txEmpty;
   assign rxPush = rxValid && !rxFullEff;
   assign overrunEvt = rxValid && rxFullEff;
   assign rxPop = rdHold && !rxEmpty;
   assign txPush = wrHold && !txFullEff;

   byte_queue #(
      .W(11),
      .DEPTH(DEPTH)
   ) rxQueue (
      .clk(clk),
      .rst_n(rst_n),
      .clear(rxClr),
      .push(rxPush),
      .pushData({rxBreak, rxFrameErr, rxParityErr, rxData}),
      .pop(rxPop),
      .headData(rxHead),
      .level(rxLevel),
      .empty(rxEmpty),
      .full(rxQFull)
   );

   byte_queue #(
      .W(8),
      .DEPTH(DEPTH)
   ) txQueue (
      .clk(clk),
      .rst_n(rst_n),
      .clear(txClr),
      .push(txPush),
      .pushData(wrData),
      .pop(txTake),
      .headData(txData),
      .level(txLevel),
      .empty(txEmpty),
      .full(txQFull)
   );

   assign txAvail = !txEmpty;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= uart_regs_pkg::MASK_RST;
      end else if (wrEn && addr == uart_regs_pkg::OFS_MASK && !dlab) begin
         mask_r <= wrData & uart_regs_pkg::MASK_WR_BITS;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         divLo_r <= uart_regs_pkg::DIV_RST;
         divHi_r <= uart_regs_pkg::DIV_RST;
      end else if (wrEn && dlab) begin
         if (addr == uart_regs_pkg::OFS_DATA) begin
            divLo_r <= wrData;
         end
         if (addr == uart_regs_pkg::OFS_MASK) begin
            divHi_r <= wrData;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfc_r <= uart_regs_pkg::LFC_RST;
         moc_r <= uart_regs_pkg::MOC_RST;
         scr_r <= uart_regs_pkg::SCR_RST;
      end else if (wrEn) begin
         if (addr == uart_regs_pkg::OFS_LFC) begin
            lfc_r <= wrData;
         end
         if (addr == uart_regs_pkg::OFS_MOC) begin
            moc_r <= wrData & uart_regs_pkg::MOC_RD_BITS;
         end
         if (addr == uart_regs_pkg::OFS_SCR) begin
            scr_r <= wrData;
         end
      end
   end

   // Trigger and mode fields only load when the enable bit is written as one.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qEn_r <= 1'b0;
         dma_r <= 1'b0;
         txSel_r <= 2'h0;
         rxSel_r <= 2'h0;
      end else if (wrQc) begin
         qEn_r <= wrData[uart_regs_pkg::QC_EN];
         if (wrData[uart_regs_pkg::QC_EN]) begin
            dma_r <= wrData[uart_regs_pkg::QC_DMA];
            rxSel_r <= wrData[uart_regs_pkg::QC_RXSEL +: 2];
            if (special) begin
               txSel_r <= wrData[uart_regs_pkg::QC_TXSEL +: 2];
            end
         end
      end
   end

   assign rxTrig = trigLevel(rxSel_r);
   assign txTrig = special ? trigLevel(txSel_r) : uart_regs_pkg::TRIG_0;

   // A lost character wins over the clear by a status read.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overrun_r <= 1'b0;
      end else if (overrunEvt) begin
         overrun_r <= 1'b1;
      end else if (rdLine) begin
         overrun_r <= 1'b0;
      end
   end

   // Counts stored characters with any error, so bit 7 covers all slots.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         errCount_r <= '0;
      end else if (rxClr) begin
         errCount_r <= '0;
      end else begin
         if ((rxPush && (rxParityErr || rxFrameErr || rxBreak)) &&
             !(rxPop && |rxHead[10:8])) begin
            errCount_r <= LW'(errCount_r + 1'b1);
         end else if (!(rxPush && (rxParityErr || rxFrameErr || rxBreak)) &&
                      (rxPop && |rxHead[10:8])) begin
            errCount_r <= LW'(errCount_r - 1'b1);
         end
      end
   end

   assign headErr = rxEmpty ? 3'h0 : rxHead[10:8];

   // A status read mutes the line interrupt until the head or overrun moves.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lineAck_r <= 1'b0;
      end else if (overrunEvt || rxPop) begin
         lineAck_r <= 1'b0;
      end else if (rdLine) begin
         lineAck_r <= 1'b1;
      end
   end

   assign lineInt = mask_r[uart_regs_pkg::MASK_LINE] && !lineAck_r &&
                    (overrun_r || |headErr);
   // A live level compare drops code and interrupt together.
   assign rxInt = mask_r[uart_regs_pkg::MASK_RX] &&
                  (qEn_r ? (rxLevel >= LW'(rxTrig)) : !rxEmpty);

   assign txBelow = qEn_r ? (txLevel < LW'(txTrig)) : txEmpty;
   assign txSet = (txBelow && !txBelow_r) ||
                  (txBelow && !txMaskPrev_r);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txBelow_r <= 1'b1;
         txMaskPrev_r <= 1'b0;
      end else begin
         txBelow_r <= txBelow;
         txMaskPrev_r <= mask_r[uart_regs_pkg::MASK_TX];
      end
   end

   // Cleared by loading data or by dropping the mask; a fresh event wins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txInt_r <= 1'b0;
      end else if (txSet && mask_r[uart_regs_pkg::MASK_TX]) begin
         txInt_r <= 1'b1;
      end else if (txPush || !mask_r[uart_regs_pkg::MASK_TX]) begin
         txInt_r <= 1'b0;
      end
   end

   // Pins come from outside and pass two flops before use.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modemMeta_r <= 4'hF;
         modemSync_r <= 4'hF;
         modemPrev_r <= 4'hF;
      end else begin
         modemMeta_r <= {cdN, riN, dsrN, ctsN};
         modemSync_r <= modemMeta_r;
         modemPrev_r <= modemSync_r;
      end
   end

   // A change seen during the clearing read is kept.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         delta_r <= 4'h0;
      end else begin
         delta_r <= (delta_r & ~{4{rdModem}}) | (modemSync_r ^ modemPrev_r);
      end
   end

   assign modemInt = mask_r[uart_regs_pkg::MASK_MODEM] && |delta_r;

   // Only the highest pending source is shown; others wait their turn.
   always_comb begin
      if (lineInt) begin
         srcCode = uart_regs_pkg::CODE_LINE;
      end else if (rxInt) begin
         srcCode = uart_regs_pkg::CODE_RX;
      end else if (txInt_r) begin
         srcCode = uart_regs_pkg::CODE_TX;
      end else if (modemInt) begin
         srcCode = uart_regs_pkg::CODE_MODEM;
      end else begin
         srcCode = uart_regs_pkg::CODE_NONE;
      end
   end

   assign srcVal = {qEn_r, qEn_r,
                    special && rxEmpty,
                    special && txFullEff,
                    srcCode};

   assign lineVal = {errCount_r != '0,
                     txEmpty && txShifterEmpty,
                     txEmpty,
                     headErr,
                     overrun_r,
                     !rxEmpty};

   assign modemVal = {~modemSync_r, delta_r};

   always_comb begin
      rdMux = 8'h00;
      unique case (addr)
         uart_regs_pkg::OFS_DATA: rdMux = dlab ? divLo_r : rxHead[7:0];
         uart_regs_pkg::OFS_MASK: rdMux = dlab ? divHi_r : mask_r;
         uart_regs_pkg::OFS_SRC: rdMux = srcVal;
         uart_regs_pkg::OFS_LFC: rdMux = lfc_r;
         uart_regs_pkg::OFS_MOC: rdMux = moc_r;
         uart_regs_pkg::OFS_LINE: rdMux = lineVal;
         uart_regs_pkg::OFS_MIC: rdMux = modemVal;
         uart_regs_pkg::OFS_SCR: rdMux = scr_r;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_r <= 8'h00;
      end else if (rdEn) begin
         rdData_r <= rdMux;
      end
   end

   assign rdData = rdData_r;
   assign intrOut = (srcCode != uart_regs_pkg::CODE_NONE) &&
                    moc_r[uart_regs_pkg::MOC_INTEN];
   assign lineFormat = lfc_r;
   assign divisor = {divHi_r, divLo_r};
   assign dtrN = !moc_r[uart_regs_pkg::MOC_DTR];
   assign rtsN = !moc_r[uart_regs_pkg::MOC_RTS];
   assign loopback = moc_r[uart_regs_pkg::MOC_LOOP];
   assign powerDown = special && moc_r[uart_regs_pkg::MOC_PDOWN];
   // The soft reset only reaches the output pin, never this block.
   assign softRstOut = !rst_n ||
                       (special && moc_r[uart_regs_pkg::MOC_SOFT]);
   assign dmaMode = dma_r;
endmodule

// ==== uart_register_map_asserts.sv ====
`timescale 1ns/100ps
module uart_register_map_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] addr,
   input wire logic rdEn,
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdData,
   input wire logic rxValid,
   input wire logic txAvail,
   input wire logic txShifterEmpty,
   input wire logic intrOut,
   input wire logic [7:0] lineFormat,
   input wire logic [15:0] divisor,
   input wire logic powerDown
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(logic [2:0] a);
      rdEn && !wrEn && addr == a;
   endsequence
   // The idle cycle matches how the host paces a status poll after a byte.
   sequence s_rxThenLine;
      rxValid && !rdEn && !wrEn ##1 !rdEn && !wrEn
         ##1 s_rd(uart_regs_pkg::OFS_LINE);
   endsequence
   property p_maskZero;
      s_rd(uart_regs_pkg::OFS_MASK) ##0 !lineFormat[7]
         |=> rdData[7:6] == 2'h0 && !rdData[4];
   endproperty
   a_maskZero: assert property (p_maskZero)
      else $error("mask reserved bits read nonzero");
   property p_divLow;
      s_rd(uart_regs_pkg::OFS_DATA) ##0 lineFormat[7]
         |=> rdData == $past(divisor[7:0]);
   endproperty
   a_divLow: assert property (p_divLow)
      else $error("offset 0 did not return divisor low byte");
   property p_divHigh;
      s_rd(uart_regs_pkg::OFS_MASK) ##0 lineFormat[7]
         |=> rdData == $past(divisor[15:8]);
   endproperty
   a_divHigh: assert property (p_divHigh)
      else $error("offset 1 did not return divisor high byte");
   property p_srcTop;
      s_rd(uart_regs_pkg::OFS_SRC) |=> rdData[7] == rdData[6];
   endproperty
   a_srcTop: assert property (p_srcTop)
      else $error("source bits 7 and 6 disagree");
   property p_srcPend;
      s_rd(uart_regs_pkg::OFS_SRC) ##0 intrOut |=> !rdData[0];
   endproperty
   a_srcPend: assert property (p_srcPend)
      else $error("source read shows none while interrupt is out");
   property p_pdown;
      wrEn && addr == uart_regs_pkg::OFS_MASK && !lineFormat[7]
         && !wrData[5] |=> !powerDown;
   endproperty
   a_pdown: assert property (p_pdown)
      else $error("power down without special mode");
   property p_rxReady;
      s_rxThenLine |=> rdData[0];
   endproperty
   a_rxReady: assert property (p_rxReady)
      else $error("data ready clear after a received byte");
   property p_lsrTx;
      s_rd(uart_regs_pkg::OFS_LINE) |=> rdData[5] == !$past(txAvail)
         && rdData[6] == ($past(txShifterEmpty) && !$past(txAvail));
   endproperty
   a_lsrTx: assert property (p_lsrTx)
      else $error("transmit empty bits wrong");
endmodule

bind uart_register_map uart_register_map_asserts chk (
   .clk(clk), .rst_n(rst_n), .addr(addr), .rdEn(rdEn), .wrEn(wrEn),
   .wrData(wrData), .rdData(rdData), .rxValid(rxValid), .txAvail(txAvail),
   .txShifterEmpty(txShifterEmpty), .intrOut(intrOut),
   .lineFormat(lineFormat), .divisor(divisor), .powerDown(powerDown)
);

// ==== uart_host_model.sv ====
`timescale 1ns/100ps
module uart_host_model (
   input wire logic clk,
   output logic [2:0] addr,
   output logic rdEn,
   output logic wrEn,
   output logic [7:0] wrData
);
   initial begin
      addr = 3'h0;
      rdEn = 1'b0;
      wrEn = 1'b0;
      wrData = 8'h00;
   end
   // Released lines show the inverse so a stale value is never trusted.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
      addr <= ~a;
      wrData <= ~d;
   endtask
   // Status is polled by plain reads, interrupt or not.
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      addr <= ~a;
   endtask
endmodule

// ==== tb_uart_register_map.sv ====
`timescale 1ns/100ps
module tb_uart_register_map;
   logic clk, rst_n, rdEn, wrEn, rxValid, rxParityErr, rxFrameErr, rxBreak;
   logic txTake, txShifterEmpty, ctsN, dsrN, riN, cdN, txAvail, intrOut;
   logic dtrN, rtsN, loopback, powerDown, softRstOut, dmaMode;
   logic [2:0] addr;
   logic [7:0] wrData, rdData, rxData, txData, lineFormat, v, w;
   logic [15:0] divisor;
   logic [4:0] ctlOut;
   logic [10:0] expQ[$];
   logic [10:0] e;
   logic rdPend = 1'b0;
   int bad_count = 0;
   int checks_done = 0;
   int seed, i;
   uart_register_map dut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .rdEn(rdEn), .wrEn(wrEn),
      .wrData(wrData), .rdData(rdData), .rxValid(rxValid), .rxData(rxData),
      .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr),
      .rxBreak(rxBreak), .txData(txData), .txAvail(txAvail),
      .txTake(txTake), .txShifterEmpty(txShifterEmpty), .ctsN(ctsN),
      .dsrN(dsrN), .riN(riN), .cdN(cdN), .intrOut(intrOut),
      .lineFormat(lineFormat), .divisor(divisor), .dtrN(dtrN),
      .rtsN(rtsN), .loopback(loopback), .powerDown(powerDown),
      .softRstOut(softRstOut), .dmaMode(dmaMode)
   );
   uart_host_model host (
      .clk(clk), .addr(addr), .rdEn(rdEn), .wrEn(wrEn), .wrData(wrData)
   );
   assign ctlOut = {powerDown, softRstOut, loopback, dtrN, rtsN};
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cmp(input string n, input logic [15:0] x,
                      input logic [15:0] y);
      checks_done++;
      if (x !== y) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, x, y);
      end
   endtask
   task automatic chk(input logic [2:0] a, input logic [7:0] x);
      expQ.push_back({a, x});
      host.rd(a);
   endtask
   task automatic rx(input logic [7:0] d, input logic [2:0] er);
      @(posedge clk);
      rxValid <= 1'b1;
      rxData <= d;
      {rxBreak, rxFrameErr, rxParityErr} <= er;
      @(posedge clk);
      rxValid <= 1'b0;
      rxData <= ~d;
   endtask
   // Read data is registered, so it is judged one edge after the request.
   always @(posedge clk) begin
      if (rdPend) begin
         e = expQ.pop_front();
         cmp($sformatf("offset%0d", e[10:8]), {8'h00, e[7:0]},
             {8'h00, rdData});
      end
      rdPend <= rdEn;
   end
   // The whole sequence needs well under a thousand cycles.
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end
   initial begin
      seed = 4;
      rst_n = 1'b0;
      {rxValid, rxParityErr, rxFrameErr, rxBreak, txTake} = 5'h00;
      rxData = 8'h00;
      {txShifterEmpty, ctsN, dsrN, riN, cdN} = 5'h1F;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      chk(3'h1, 8'h00);
      chk(3'h3, 8'h00);
      chk(3'h7, 8'h00);
      chk(3'h2, 8'h01);
      chk(3'h5, 8'h60);
      v = 8'($random(seed));
      host.wr(3'h7, v);
      chk(3'h7, v);
      host.wr(3'h1, 8'hFF);
      chk(3'h1, 8'h2F);
      host.wr(3'h1, 8'h20);
      chk(3'h2, 8'h21);
      host.wr(3'h4, 8'hF7);
      chk(3'h4, 8'h97);
      #1 cmp("ctlOut", 16'h001C, {11'h0, ctlOut});
      host.wr(3'h1, 8'h00);
      #1 cmp("ctlOut", 16'h0004, {11'h0, ctlOut});
      host.wr(3'h3, 8'h80);
      v = 8'($random(seed));
      w = 8'($random(seed));
      host.wr(3'h0, v);
      host.wr(3'h1, w);
      chk(3'h0, v);
      chk(3'h1, w);
      #1 cmp("divisor", {w, v}, divisor);
      host.wr(3'h3, 8'h03);
      chk(3'h1, 8'h00);
      chk(3'h3, 8'h03);
      host.wr(3'h4, 8'h08);
      host.wr(3'h1, 8'h01);
      rx(8'h5A, 3'h0);
      chk(3'h5, 8'h61);
      chk(3'h2, 8'h04);
      #1 cmp("intrOut", 16'h1, {15'h0, intrOut});
      chk(3'h0, 8'h5A);
      chk(3'h5, 8'h60);
      chk(3'h2, 8'h01);
      rx(8'h11, 3'h0);
      rx(8'h22, 3'h0);
      host.wr(3'h1, 8'h05);
      chk(3'h2, 8'h06);
      chk(3'h5, 8'h63);
      chk(3'h2, 8'h04);
      chk(3'h0, 8'h11);
      host.wr(3'h1, 8'h02);
      chk(3'h2, 8'h02);
      host.wr(3'h0, 8'h33);
      #1 cmp("txData", 16'h0133, {7'h0, txAvail, txData});
      chk(3'h5, 8'h00);
      chk(3'h2, 8'h01);
      txShifterEmpty <= 1'b0;
      @(posedge clk);
      txTake <= 1'b1;
      @(posedge clk);
      txTake <= 1'b0;
      chk(3'h5, 8'h20);
      chk(3'h2, 8'h02);
      txShifterEmpty <= 1'b1;
      chk(3'h5, 8'h60);
      host.wr(3'h1, 8'h00);
      host.wr(3'h2, 8'h49);
      #1 cmp("dmaMode", 16'h1, {15'h0, dmaMode});
      chk(3'h2, 8'hC1);
      host.wr(3'h1, 8'h01);
      for (i = 0; i < 4; i++) begin
         rx(8'(i), 3'h0);
         chk(3'h2, i < 3 ? 8'hC1 : 8'hC4);
      end
      chk(3'h0, 8'h00);
      chk(3'h2, 8'hC1);
      host.wr(3'h1, 8'h00);
      chk(3'h5, 8'h61);
      host.wr(3'h2, 8'h43);
      #1 cmp("dmaMode", 16'h0, {15'h0, dmaMode});
      chk(3'h5, 8'h60);
      for (i = 0; i < 3; i++) begin
         rx(8'hA0, 3'(1 << i));
         chk(3'h5, 8'hE1 | (8'h04 << i));
         chk(3'h0, 8'hA0);
      end
      rx(8'h55, 3'h0);
      rx(8'h44, 3'h4);
      chk(3'h5, 8'hE1);
      chk(3'h0, 8'h55);
      chk(3'h5, 8'hF1);
      chk(3'h0, 8'h44);
      for (i = 0; i < 17; i++) begin
         rx(8'($random(seed)), 3'h0);
      end
      chk(3'h5, 8'h63);
      host.wr(3'h2, 8'h43);
      host.wr(3'h1, 8'h08);
      ctsN <= 1'b0;
      repeat (6) @(posedge clk);
      chk(3'h2, 8'hC0);
      chk(3'h6, 8'h11);
      chk(3'h2, 8'hC1);
      repeat (2) @(posedge clk);
      finish_test();
   end
endmodule
